// ===== sensor_cfg_pkg.sv
// constants and types shared by the sensor configuration access logic
package sensor_cfg_pkg;
    // bus target address (7 bits) and command bytes
    localparam logic [6:0] DEV_ADDR = 7'h54;
    localparam logic [7:0] CMD_RD = 8'hA7;
    localparam logic [7:0] CMD_WR = 8'hA6;
    localparam logic [7:0] CMD_STOP = 8'h30;
    // register offsets and reset values
    localparam logic [7:0] REG_RES = 8'h00;
    localparam logic [7:0] REG_PER = 8'h02;
    localparam logic [7:0] RES_RST = 8'h0F;
    localparam logic [7:0] PER_RST = 8'h00;
    // field positions
    localparam int RES_TEMP_LSB = 0;
    localparam int RES_HUM_LSB = 2;
    localparam int PER_RUN_BIT = 7;
    localparam int PER_IVL_LSB = 4;
    // periodic intervals: printed time and derived cycle counts at 40 MHz
    localparam int CLK_KHZ = 40_000;
    localparam int IVL0_MS = 500;
    localparam int IVL1_MS = 1000;
    localparam int IVL2_MS = 2500;
    localparam int IVL0_CYC = IVL0_MS * CLK_KHZ;
    localparam int IVL1_CYC = IVL1_MS * CLK_KHZ;
    localparam int IVL2_CYC = IVL2_MS * CLK_KHZ;
    // bit-level and command-level states
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} i2cState_t;
    typedef enum logic [2:0] {SQ_NONE, SQ_CMD, SQ_RA_RD, SQ_RA_WR, SQ_WRDATA, SQ_RDREADY} seq_t;
endpackage

// ===== cfg_regs.sv
// configuration register storage with registered read data
`timescale 1ns/1ps
module cfg_regs
    import sensor_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write and read port
    input wire logic wrEn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic runActive,
    output logic [7:0] rdData_ff,
    // stored fields
    output logic [7:0] resCfg_ff,
    output logic [7:0] perCfg_ff
);
    logic [7:0] nxt_rdData;
    logic [7:0] nxt_resCfg;
    logic [7:0] nxt_perCfg;

    // write decode and read mux; the run bit reads the live run flag
    always_comb begin
        nxt_resCfg = resCfg_ff;
        nxt_perCfg = perCfg_ff;
        if (wrEn && addr == REG_RES) begin
            nxt_resCfg = wrData;
        end else if (wrEn && addr == REG_PER) begin
            nxt_perCfg = wrData & 8'h7F;
        end
        if (addr == REG_RES) begin
            nxt_rdData = resCfg_ff;
        end else if (addr == REG_PER) begin
            nxt_rdData = {runActive, perCfg_ff[6:0]};
        end else begin
            nxt_rdData = 8'h00;
        end
    end

    // defaults restored on every power-up reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resCfg_ff <= RES_RST;
            perCfg_ff <= PER_RST;
            rdData_ff <= 8'h00;
        end else begin
            resCfg_ff <= nxt_resCfg;
            perCfg_ff <= nxt_perCfg;
            rdData_ff <= nxt_rdData;
        end
    end
endmodule

// ===== sensor_cfg_access.sv
// bus target for configuration register access and periodic run control
// Operation
// - power-up reset restores every configuration register default
// - answer 7-bit address plus direction; ack address, command, address, data
// - address with write bit wakes device for the following command
// - command 0xA7 after address-write starts a register read
// - address with read bit makes device send the selected register
// - command 0xA6 after address-write starts a register write
// - following data byte is stored into the addressed register
// - measurement_resolution_config bits 1:0 select temperature resolution 8/10/12/14
// - measurement_resolution_config bits 3:2 select humidity resolution, same encoding
// - writing one to periodic_measurement_config bit 7 starts periodic measurement
// - periodic_measurement_config bit 7 reads zero while periodic mode inactive
// - periodic_measurement_config bits 5:4 set interval 0.5 s, 1 s, 2.5 s
// - while running only stop command 0x30 accepted; it returns to sleep
`timescale 1ns/1ps
module sensor_cfg_access
    import sensor_cfg_pkg::*;
#(
    parameter int IVL_CYC_0 = IVL0_CYC,
    parameter int IVL_CYC_1 = IVL1_CYC,
    parameter int IVL_CYC_2 = IVL2_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus pins
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    // configuration and status
    output logic [1:0] tempRes,
    output logic [1:0] humRes,
    output logic periodicOn,
    output logic measTick,
    output logic awake
);
    logic sclMeta_ff, sclSync_ff, sclDly_ff;
    logic sdaMeta_ff, sdaSync_ff, sdaDly_ff;
    logic sclRise, sclFall, startCond, stopCond;
    i2cState_t state_ff, nxt_state;
    seq_t seq_ff, nxt_seq;
    logic addrByte_ff, nxt_addrByte;
    logic [3:0] bitCnt_ff, nxt_bitCnt;
    logic [7:0] shift_ff, nxt_shift;
    logic acked_ff, nxt_acked;
    logic goTx_ff, nxt_goTx;
    logic [7:0] regAddr_ff, nxt_regAddr;
    logic wrEn_ff, nxt_wrEn;
    logic [7:0] wrData_ff, nxt_wrData;
    logic sdaOeN_ff, nxt_sdaOeN;
    logic periodicOn_ff, nxt_periodicOn;
    logic awake_ff, nxt_awake;
    logic [26:0] cnt_ff, nxt_cnt;
    logic measTick_ff, nxt_measTick;
    logic [26:0] ivlLimit;
    logic [7:0] rdData;
    logic [7:0] resCfg;
    logic [7:0] perCfg;
    logic byteDone;

    // two-stage synchronisers plus one delay stage for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclMeta_ff <= 1'b1;
            sclSync_ff <= 1'b1;
            sclDly_ff <= 1'b1;
            sdaMeta_ff <= 1'b1;
            sdaSync_ff <= 1'b1;
            sdaDly_ff <= 1'b1;
        end else begin
            sclMeta_ff <= scl;
            sclSync_ff <= sclMeta_ff;
            sclDly_ff <= sclSync_ff;
            sdaMeta_ff <= sdaIn;
            sdaSync_ff <= sdaMeta_ff;
            sdaDly_ff <= sdaSync_ff;
        end
    end

    // bus events
    assign sclRise = sclSync_ff && !sclDly_ff;
    assign sclFall = !sclSync_ff && sclDly_ff;
    assign startCond = sclSync_ff && sclDly_ff && sdaDly_ff && !sdaSync_ff;
    assign stopCond = sclSync_ff && sclDly_ff && !sdaDly_ff && sdaSync_ff;
    assign byteDone = state_ff == ST_RX && sclFall && bitCnt_ff == 4'h8;

    // register storage
    cfg_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(wrEn_ff),
        .addr(regAddr_ff),
        .wrData(wrData_ff),
        .runActive(periodicOn_ff),
        .rdData_ff(rdData),
        .resCfg_ff(resCfg),
        .perCfg_ff(perCfg)
    );

    // bit engine and command sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_seq = seq_ff;
        nxt_addrByte = addrByte_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_shift = shift_ff;
        nxt_acked = acked_ff;
        nxt_goTx = goTx_ff;
        nxt_regAddr = regAddr_ff;
        nxt_wrEn = 1'b0;
        nxt_wrData = wrData_ff;
        nxt_sdaOeN = sdaOeN_ff;
        nxt_periodicOn = periodicOn_ff;
        nxt_awake = awake_ff;
        if (stopCond) begin
            nxt_state = ST_IDLE;
            nxt_seq = SQ_NONE;
            nxt_sdaOeN = 1'b1;
            nxt_awake = 1'b0;
        end else if (startCond) begin
            // repeated start keeps the command sequence
            nxt_state = ST_RX;
            nxt_addrByte = 1'b1;
            nxt_bitCnt = 4'h0;
            nxt_sdaOeN = 1'b1;
        end else begin
            case (state_ff)
                ST_RX: begin
                    if (sclRise && bitCnt_ff != 4'h8) begin
                        nxt_shift = {shift_ff[6:0], sdaSync_ff};
                        nxt_bitCnt = 4'(bitCnt_ff + 4'h1);
                    end else if (byteDone) begin
                        nxt_state = ST_ACK;
                        nxt_acked = 1'b1;
                        nxt_goTx = 1'b0;
                        nxt_addrByte = 1'b0;
                        if (addrByte_ff) begin
                            if (shift_ff[7:1] != DEV_ADDR) begin
                                nxt_acked = 1'b0;
                            end else if (!shift_ff[0]) begin
                                nxt_awake = 1'b1;
                                nxt_seq = SQ_CMD;
                            end else if (seq_ff == SQ_RDREADY) begin
                                nxt_goTx = 1'b1;
                                nxt_seq = SQ_NONE;
                            end else begin
                                nxt_acked = 1'b0;
                            end
                        end else begin
                            case (seq_ff)
                                SQ_CMD: begin
                                    nxt_seq = SQ_NONE;
                                    if (periodicOn_ff) begin
                                        if (shift_ff == CMD_STOP) begin
                                            nxt_periodicOn = 1'b0;
                                        end else begin
                                            nxt_acked = 1'b0;
                                        end
                                    end else if (shift_ff == CMD_RD) begin
                                        nxt_seq = SQ_RA_RD;
                                    end else if (shift_ff == CMD_WR) begin
                                        nxt_seq = SQ_RA_WR;
                                    end
                                end
                                SQ_RA_RD: begin
                                    nxt_regAddr = shift_ff;
                                    nxt_seq = SQ_RDREADY;
                                end
                                SQ_RA_WR: begin
                                    nxt_regAddr = shift_ff;
                                    nxt_seq = SQ_WRDATA;
                                end
                                SQ_WRDATA: begin
                                    nxt_wrEn = 1'b1;
                                    nxt_wrData = shift_ff;
                                    nxt_seq = SQ_NONE;
                                    if (regAddr_ff == REG_PER && shift_ff[PER_RUN_BIT]) begin
                                        nxt_periodicOn = 1'b1;
                                    end
                                end
                                default: begin
                                    nxt_seq = seq_ff;
                                end
                            endcase
                        end
                        nxt_sdaOeN = !nxt_acked;
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        nxt_bitCnt = 4'h0;
                        nxt_sdaOeN = 1'b1;
                        if (!acked_ff) begin
                            nxt_state = ST_IDLE;
                        end else if (goTx_ff) begin
                            nxt_state = ST_TX;
                            nxt_shift = rdData;
                            nxt_sdaOeN = rdData[7];
                            nxt_bitCnt = 4'h1;
                        end else begin
                            nxt_state = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (bitCnt_ff == 4'h8) begin
                            nxt_sdaOeN = 1'b1;
                            nxt_state = ST_TXACK;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_sdaOeN = shift_ff[6];
                            nxt_bitCnt = 4'(bitCnt_ff + 4'h1);
                        end
                    end
                end
                ST_TXACK: begin
                    // one byte per read; host nack then stop
                    if (sclRise) begin
                        nxt_state = ST_IDLE;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            seq_ff <= SQ_NONE;
            addrByte_ff <= 1'b0;
            bitCnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            acked_ff <= 1'b0;
            goTx_ff <= 1'b0;
            regAddr_ff <= 8'h00;
            wrEn_ff <= 1'b0;
            wrData_ff <= 8'h00;
            sdaOeN_ff <= 1'b1;
            periodicOn_ff <= 1'b0;
            awake_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            seq_ff <= nxt_seq;
            addrByte_ff <= nxt_addrByte;
            bitCnt_ff <= nxt_bitCnt;
            shift_ff <= nxt_shift;
            acked_ff <= nxt_acked;
            goTx_ff <= nxt_goTx;
            regAddr_ff <= nxt_regAddr;
            wrEn_ff <= nxt_wrEn;
            wrData_ff <= nxt_wrData;
            sdaOeN_ff <= nxt_sdaOeN;
            periodicOn_ff <= nxt_periodicOn;
            awake_ff <= nxt_awake;
        end
    end

    // interval select; reserved code runs at the slowest rate
    always_comb begin
        case (perCfg[PER_IVL_LSB +: 2])
            2'b00: ivlLimit = 27'(IVL_CYC_0);
            2'b01: ivlLimit = 27'(IVL_CYC_1);
            default: ivlLimit = 27'(IVL_CYC_2);
        endcase
        nxt_cnt = 27'h0;
        nxt_measTick = 1'b0;
        if (periodicOn_ff) begin
            if (cnt_ff >= 27'(ivlLimit - 27'h1)) begin
                nxt_measTick = 1'b1;
            end else begin
                nxt_cnt = 27'(cnt_ff + 27'h1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 27'h0;
            measTick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            measTick_ff <= nxt_measTick;
        end
    end

    // outputs
    assign sdaOut = 1'b0;
    assign sdaOe_n = sdaOeN_ff;
    assign tempRes = resCfg[RES_TEMP_LSB +: 2];
    assign humRes = resCfg[RES_HUM_LSB +: 2];
    assign periodicOn = periodicOn_ff;
    assign measTick = measTick_ff;
    assign awake = awake_ff;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_addr_ack_wake: assert property (byteDone && addrByte_ff && shift_ff[7:1] == DEV_ADDR
        && !shift_ff[0] |=> !sdaOeN_ff && awake_ff && seq_ff == SQ_CMD)
        else $error("address write not acked");
    a_rd_cmd_seq: assert property (byteDone && !addrByte_ff && seq_ff == SQ_CMD && !periodicOn_ff
        && shift_ff == CMD_RD |=> seq_ff == SQ_RA_RD && !sdaOeN_ff)
        else $error("read command not taken");
    a_wr_cmd_seq: assert property (byteDone && !addrByte_ff && seq_ff == SQ_CMD && !periodicOn_ff
        && shift_ff == CMD_WR |=> seq_ff == SQ_RA_WR)
        else $error("write command not taken");
    a_tx_first_bit: assert property (state_ff == ST_ACK && sclFall && acked_ff && goTx_ff
        |=> state_ff == ST_TX && sdaOeN_ff == $past(rdData[7]))
        else $error("read data not driven");
    a_res_store: assert property (wrEn_ff && regAddr_ff == REG_RES
        |=> tempRes == $past(wrData_ff[1:0]) && humRes == $past(wrData_ff[3:2]))
        else $error("resolution not stored");
    a_run_start: assert property (byteDone && seq_ff == SQ_WRDATA && regAddr_ff == REG_PER
        && !addrByte_ff && shift_ff[7] |=> periodicOn_ff ##1 !wrEn_ff)
        else $error("periodic run not started");
    a_run_readback: assert property (!periodicOn_ff && regAddr_ff == REG_PER
        |=> !rdData[7])
        else $error("run bit reads one while idle");
    a_stop_cmd: assert property (byteDone && !addrByte_ff && seq_ff == SQ_CMD && periodicOn_ff
        |=> periodicOn_ff == (($past(shift_ff) != CMD_STOP)) && sdaOeN_ff == periodicOn_ff)
        else $error("busy command handling wrong");
    a_tick_interval: assert property (measTick_ff
        |-> $past(cnt_ff) == 27'($past(ivlLimit) - 27'h1))
        else $error("measurement tick at wrong interval");
endmodule

// ===== host_bus_model.sv
// bus master model that drives the clock and data lines of the sensor target
`timescale 1ns/1ps
module host_bus_model (
    // bus lines (sdaDrv high = released to the pull-up)
    output logic scl,
    output logic sdaDrv,
    input wire logic sdaLine
);
    // idle bus: both lines released, clock stands still between frames
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    // start or repeated start; waits out the target's ack hold first
    task automatic busStart();
        #120 sdaDrv = 1'b1;
        #40 scl = 1'b1;
        #80 sdaDrv = 1'b0;
        #80 scl = 1'b0;
    endtask

    // stop: data rises while the clock is high
    task automatic busStop();
        #60 sdaDrv = 1'b0;
        #60 scl = 1'b1;
        #80 sdaDrv = 1'b1;
        #80;
    endtask

    // one byte out, msb first, then sample the target's ack
    task automatic putByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #60 sdaDrv = b[i];
            #60 scl = 1'b1;
            #80 scl = 1'b0;
        end
        #60 sdaDrv = 1'b1;
        #60 scl = 1'b1;
        #40 ack = sdaLine;
        #40 scl = 1'b0;
    endtask

    // one byte in, msb first, then answer with ack (0) or nack (1)
    task automatic getByte(output logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) begin
            #60 sdaDrv = 1'b1;
            #60 scl = 1'b1;
            #40 b[i] = sdaLine;
            #40 scl = 1'b0;
        end
        #60 sdaDrv = nack;
        #60 scl = 1'b1;
        #80 scl = 1'b0;
    endtask
endmodule

// ===== testbench.sv
// self-checking bench for the sensor configuration access logic
`timescale 1ns/1ps
module testbench
    import sensor_cfg_pkg::*;
;
    localparam int IVL_A = 40;
    localparam int IVL_B = 80;
    localparam int IVL_C = 200;
    typedef struct {logic [7:0] addr; logic [7:0] data; logic [7:0] rdExp;
                    logic [1:0] t; logic [1:0] h;} row_t;
    logic clk, rst_n, scl, sdaDrv, sdaOut, sdaOe_n, periodicOn, measTick, awake;
    logic [1:0] tempRes, humRes;
    wire logic sdaLine;
    int fail_count = 0;
    int compares = 0;
    int ivl [4] = '{IVL_A, IVL_B, IVL_C, IVL_C};
    // register access rows: address, data written, value read back, fields
    row_t rows [8] = '{
        '{REG_RES, 8'h00, 8'h00, 2'h0, 2'h0}, '{REG_RES, 8'h05, 8'h05, 2'h1, 2'h1},
        '{REG_RES, 8'h0A, 8'h0A, 2'h2, 2'h2}, '{REG_RES, 8'hF3, 8'hF3, 2'h3, 2'h0},
        '{REG_PER, 8'h3F, 8'h3F, 2'h3, 2'h0}, '{8'h01, 8'h55, 8'h00, 2'h3, 2'h0},
        '{8'hFF, 8'hAA, 8'h00, 2'h3, 2'h0}, '{REG_RES, 8'h0F, 8'h0F, 2'h3, 2'h3}};

    // open-drain wire with pull-up: low if either party pulls
    assign sdaLine = sdaDrv & (sdaOe_n | sdaOut);

    // clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    sensor_cfg_access #(.IVL_CYC_0(IVL_A), .IVL_CYC_1(IVL_B), .IVL_CYC_2(IVL_C)) uut (
        .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n), .tempRes(tempRes), .humRes(humRes), .periodicOn(periodicOn),
        .measTick(measTick), .awake(awake));

    host_bus_model host (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

    // compare tasks and closing
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkNum(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // helpers for bus sequences and port checks
    task automatic settle();
        repeat (5) @(negedge clk);
    endtask
    task automatic fields(input logic [1:0] t, input logic [1:0] h, input logic p);
        chk8("tempRes", {6'h00, t}, {6'h00, tempRes});
        chk8("humRes", {6'h00, h}, {6'h00, humRes});
        chk8("periodicOn", {7'h00, p}, {7'h00, periodicOn});
    endtask
    task automatic regWrite(input logic [7:0] ra, input logic [7:0] wd);
        logic [3:0] a;
        host.busStart();
        host.putByte({DEV_ADDR, 1'b0}, a[3]);
        host.putByte(CMD_WR, a[2]);
        host.putByte(ra, a[1]);
        host.putByte(wd, a[0]);
        host.busStop();
        settle();
        chk8("write acks", 8'h00, {4'h0, a});
    endtask
    task automatic regRead(input logic [7:0] ra, output logic [7:0] rd);
        logic [3:0] a;
        host.busStart();
        host.putByte({DEV_ADDR, 1'b0}, a[3]);
        host.putByte(CMD_RD, a[1]);
        host.putByte(ra, a[0]);
        host.busStart();
        host.putByte({DEV_ADDR, 1'b1}, a[2]);
        host.getByte(rd, 1'b1);
        host.busStop();
        settle();
        chk8("read acks", 8'h00, {4'h0, a});
    endtask
    task automatic twoBytes(input logic [7:0] b0, input logic [7:0] b1,
                            output logic [1:0] a);
        host.busStart();
        host.putByte(b0, a[1]);
        host.putByte(b1, a[0]);
        host.busStop();
        settle();
    endtask
    task automatic measureGap(output int gap);
        int n;
        n = 0;
        @(negedge clk);
        while (measTick !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        gap = 1;
        while (measTick !== 1'b1 && gap < 1000) begin
            @(negedge clk);
            gap++;
        end
    endtask
    task automatic pulseReset();
        @(posedge clk);
        #2 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #2 rst_n = 1'b1;
        settle();
    endtask

    // main sequence
    initial begin
        logic [7:0] d;
        logic [1:0] a;
        int gap;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #2 rst_n = 1'b1;
        settle();
        fields(2'h3, 2'h3, 1'b0);
        chk8("awake", 8'h00, {7'h00, awake});
        regRead(REG_RES, d);
        chk8("reset reg 0x00", RES_RST, d);
        regRead(REG_PER, d);
        chk8("reset reg 0x02", PER_RST, d);
        $display("test reset defaults done");
        // ordinary register rows
        foreach (rows[i]) begin
            regWrite(rows[i].addr, rows[i].data);
            regRead(rows[i].addr, d);
            chk8("read back", rows[i].rdExp, d);
            fields(rows[i].t, rows[i].h, 1'b0);
        end
        $display("test register rows done");
        // read, mask, write back keeps the humidity field
        regRead(REG_RES, d);
        regWrite(REG_RES, (d & 8'hFC) | 8'h01);
        regRead(REG_RES, d);
        chk8("masked write", 8'h0D, d);
        fields(2'h1, 2'h3, 1'b0);
        $display("test read modify write done");
        // wake on own address, sleep after stop, refusals
        host.busStart();
        host.putByte({DEV_ADDR, 1'b0}, a[0]);
        settle();
        chk8("awake after address", 8'h01, {7'h00, awake});
        host.busStop();
        settle();
        chk8("awake after stop", 8'h00, {7'h00, awake});
        twoBytes({DEV_ADDR ^ 7'h01, 1'b0}, CMD_WR, a);
        chk8("foreign address acks", 8'h03, {6'h00, a});
        twoBytes({DEV_ADDR, 1'b1}, 8'h00, a);
        chk8("read without command", 8'h03, {6'h00, a});
        twoBytes({DEV_ADDR, 1'b0}, 8'h55, a);
        chk8("unknown command acks", 8'h00, {6'h00, a});
        $display("test wake and refusal done");
        // periodic mode for each interval code, refused command, stop
        for (int c = 0; c < 4; c++) begin
            regWrite(REG_PER, {2'b10, c[1:0], 4'h0});
            fields(2'h1, 2'h3, 1'b1);
            measureGap(gap);
            chkNum("tick interval", ivl[c], gap);
            twoBytes({DEV_ADDR, 1'b0}, CMD_RD, a);
            chk8("command while running", 8'h01, {6'h00, a});
            twoBytes({DEV_ADDR, 1'b0}, CMD_STOP, a);
            chk8("stop command acks", 8'h00, {6'h00, a});
            fields(2'h1, 2'h3, 1'b0);
            regRead(REG_PER, d);
            chk8("reg 0x02 after stop", {2'b00, c[1:0], 4'h0}, d);
        end
        $display("test periodic mode done");
        // second reset restores defaults
        regWrite(REG_PER, 8'h90);
        pulseReset();
        fields(2'h3, 2'h3, 1'b0);
        regRead(REG_RES, d);
        chk8("reg 0x00 after reset", RES_RST, d);
        regRead(REG_PER, d);
        chk8("reg 0x02 after reset", PER_RST, d);
        $display("test second reset done");
        end_sim();
    end

    // watchdog
    initial begin
        #2_000_000;
        fail_count++;
        $display("watchdog expired");
        end_sim();
    end
endmodule
